// [rtl/ecd_pkg.sv]
// Constants shared by the edge clock divider top and its divider core.
// How it works
// - Two independent dividers, one per side.
// - Output frequency is input divided by 2/4/8.
// - Divided phase fixed by moment of release.
// - Input selectable: PLL primary output or edge clock.
// - Divided output drives the primary clock network.
// - Reset clears input state, holds outputs low.
// - Outputs held until release; controller asserts release.
package ecd_pkg;

	// Depth of the pin synchroniser on each clock input.
	localparam int ECD_SYNC_W = 3;

	// Width of the APB address bus seen by the register file.
	localparam int ECD_ADDR_W = 12;

	// Register byte offsets.
	localparam logic [11:0] ECD_CTRL_OFS = 12'h000;
	localparam logic [11:0] ECD_STAT_OFS = 12'h004;

	// Bit positions of one side's control field inside the control word.
	localparam int ECD_RST_BIT   = 0;
	localparam int ECD_REL_BIT   = 1;
	localparam int ECD_RATIO_LSB = 2;
	localparam int ECD_SRC_BIT   = 4;

	// Base bit of each side's field in the control and status words.
	localparam int ECD_LEFT_BASE  = 0;
	localparam int ECD_RIGHT_BASE = 8;

	// Bit positions of one side's status field.
	localparam int ECD_RUN_BIT = 0;
	localparam int ECD_OUT_BIT = 1;

	// Control word after reset: both dividers held in reset, not released.
	localparam logic [31:0] ECD_CTRL_RST = 32'h0000_0101;

	// Ratio codes written by software.
	localparam logic [1:0] ECD_DIV2 = 2'h0;
	localparam logic [1:0] ECD_DIV4 = 2'h1;
	localparam logic [1:0] ECD_DIV8 = 2'h2;

	// Input rising edges per half period of the divided clock.
	localparam logic [2:0] ECD_HALF2 = 3'h1;
	localparam logic [2:0] ECD_HALF4 = 3'h2;
	localparam logic [2:0] ECD_HALF8 = 3'h4;

	// Source select values.
	localparam logic ECD_SRC_PLL  = 1'b0;
	localparam logic ECD_SRC_EDGE = 1'b1;

endpackage

// [rtl/ecd_divider.sv]
// One divider core: input synchronisers, source select and divide counter.
`timescale 1ns/1ps
module ecd_divider
	import ecd_pkg::*;
(
	input  logic       clk,
	input  logic       rst_n,
	input  logic       div_rst,
	input  logic       release_req,
	input  logic [1:0] ratio,
	input  logic       src_sel,
	input  logic       pll_primary_out,
	input  logic       edge_clock_in,
	output logic       running,
	output logic       clk_div
);

	// All state of the core, registered as one word.
	typedef struct packed {
		logic [ECD_SYNC_W-1:0] pll_sync;  // Pin synchroniser, bit 0 first.
		logic [ECD_SYNC_W-1:0] edge_sync; // Pin synchroniser, bit 0 first.
		logic                  pll_lvl;   // Settled level of the PLL input.
		logic                  edge_lvl;  // Settled level of the edge input.
		logic [1:0]            fill;      // Stages refilled since a clear.
		logic                  running;   // Output follows the input.
		logic                  src;       // Source locked while running.
		logic [2:0]            half;      // Rises per half period, locked.
		logic [2:0]            cnt;       // Rises left before next toggle.
		logic                  out;       // Divided clock.
	} ecd_div_st_t;

	ecd_div_st_t st;      // Current state.
	ecd_div_st_t next_st; // Next state.
	logic        pll_rise;  // Settled rising edge of the PLL input.
	logic        edge_rise; // Settled rising edge of the edge clock.
	logic        rise;      // Rising edge of the selected input.

	// Map a ratio code to input rises per half period.
	function automatic logic [2:0] half_of(input logic [1:0] code);
		case (code)
			ECD_DIV2: half_of = ECD_HALF2;
			ECD_DIV4: half_of = ECD_HALF4;
			default:  half_of = ECD_HALF8;
		endcase
	endfunction

	// A change counts only once the second and third stages agree.
	assign pll_rise  = st.pll_sync[1] & st.pll_sync[2] & ~st.pll_lvl;
	assign edge_rise = st.edge_sync[1] & st.edge_sync[2] & ~st.edge_lvl;
	assign rise      = (st.src == ECD_SRC_EDGE) ? edge_rise : pll_rise;

	// Next-state logic of the core.
	always_comb begin
		next_st = st;
		next_st.pll_sync  = {st.pll_sync[1:0], pll_primary_out};
		next_st.edge_sync = {st.edge_sync[1:0], edge_clock_in};
		if (st.fill != 2'(ECD_SYNC_W)) begin
			// Stages still hold cleared zeros: the level is primed from
			// the pin samples, so a pin that is already high after a
			// clear is not taken for a rise and cannot cut a runt pulse.
			next_st.fill     = 2'(st.fill + 2'h1);
			next_st.pll_lvl  = st.pll_sync[1];
			next_st.edge_lvl = st.edge_sync[1];
		end else begin
			// Normal tracking once all stages carry pin samples.
			if (st.pll_sync[1] == st.pll_sync[2]) begin
				next_st.pll_lvl = st.pll_sync[2];
			end
			if (st.edge_sync[1] == st.edge_sync[2]) begin
				next_st.edge_lvl = st.edge_sync[2];
			end
		end
		if (div_rst) begin
			// Input side cleared and output forced low.
			next_st = '0;
		end else if (!st.running) begin
			// Configuration is taken while idle, so the phase is fixed
			// by the release alone and not by later register writes.
			next_st.half    = half_of(ratio);
			next_st.src     = src_sel;
			next_st.cnt     = 3'h0;
			next_st.out     = 1'b0;
			next_st.running = release_req;
		end else if (rise) begin
			// First rise after release toggles at once: the output rises
			// on an input rise and every later edge is a fixed count.
			if (st.cnt == 3'h0) begin
				next_st.out = ~st.out;
				next_st.cnt = 3'(st.half - 3'h1);
			end else begin
				next_st.cnt = 3'(st.cnt - 3'h1);
			end
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign running = st.running;
	assign clk_div = st.out;

	// Helper: rises seen since the last toggle, for the period check.
	logic [2:0] chk_rises; // Rises since last toggle.
	logic       chk_seen;  // At least one toggle since release.
	always_ff @(posedge clk) begin
		if (!rst_n || div_rst || !st.running) begin
			chk_rises <= 3'h0;
			chk_seen  <= 1'b0;
		end else if (rise && st.cnt == 3'h0) begin
			chk_rises <= 3'h0;
			chk_seen  <= 1'b1;
		end else if (rise) begin
			chk_rises <= 3'(chk_rises + 3'h1);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_reset_holds_low: assert property (
		div_rst |=> !clk_div && !running && st.pll_sync == '0)
		else $error("divider output not low during reset");

	a_hold_until_rel: assert property (
		!running && !release_req |=> !clk_div && !running)
		else $error("divider output left hold without release");

	a_first_on_rise: assert property (
		$rose(clk_div) |-> $past(rise) && $past(running))
		else $error("divided clock rose without an input rise");

	a_phase_at_rel: assert property (
		$rose(running) |-> !clk_div && st.cnt == 3'h0 ##0 $past(release_req))
		else $error("divider did not start from a fixed phase");

	a_ratio_period: assert property (
		running && chk_seen && rise && st.cnt == 3'h0 |->
			3'(chk_rises + 3'h1) == st.half)
		else $error("divided half period has wrong input count");

	a_source_gated: assert property (
		running && !div_rst && st.src == ECD_SRC_PLL && !pll_rise
		|=> $stable(clk_div))
		else $error("divided clock moved without a PLL input rise");

	c_div8_toggle: cover property (
		running && st.half == ECD_HALF8 && chk_seen && $changed(clk_div));
	c_edge_source: cover property (
		running && st.src == ECD_SRC_EDGE && $rose(clk_div));

endmodule // ecd_divider

// [rtl/ecd_top.sv]
// Edge clock divider pair with an APB register file.
`timescale 1ns/1ps
module ecd_top
	import ecd_pkg::*;
(
	input  logic                  clk,
	input  logic                  rst_n,
	input  logic [ECD_ADDR_W-1:0] paddr,
	input  logic                  psel,
	input  logic                  penable,
	input  logic                  pwrite,
	input  logic [31:0]           pwdata,
	input  logic [3:0]            pstrb,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  logic                  left_pll_primary_out,
	input  logic                  left_edge_clock_in,
	input  logic                  right_pll_primary_out,
	input  logic                  right_edge_clock_in,
	output logic                  left_clk_div,
	output logic                  right_clk_div
);

	// All state of the register file, registered as one word.
	typedef struct packed {
		logic [31:0] ctrl;    // Control word for both sides.
		logic        pready;  // Access completes on this cycle.
		logic [31:0] prdata;  // Read data, valid with pready.
		logic        pslverr; // Unmapped address flag, valid with pready.
	} ecd_top_st_t;

	ecd_top_st_t st;      // Current state.
	ecd_top_st_t next_st; // Next state.
	logic        left_run;  // Left divider released and running.
	logic        right_run; // Right divider released and running.
	logic [31:0] stat_word; // Live status word.
	logic        access;    // Access phase of a transfer.
	logic        hit_ctrl;  // Address names the control word.
	logic        hit_stat;  // Address names the status word.

	// True when an address names a given register word.
	function automatic logic reg_hit(input logic [ECD_ADDR_W-1:0] a,
			input logic [ECD_ADDR_W-1:0] ofs);
		reg_hit = (a[ECD_ADDR_W-1:2] == ofs[ECD_ADDR_W-1:2]);
	endfunction

	// Merge write data into a word under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge = res;
	endfunction

	assign access   = psel & penable;
	assign hit_ctrl = reg_hit(paddr, ECD_CTRL_OFS);
	assign hit_stat = reg_hit(paddr, ECD_STAT_OFS);

	// Status word: each side reports running and its divided level.
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[ECD_LEFT_BASE + ECD_RUN_BIT]  = left_run;
		stat_word[ECD_LEFT_BASE + ECD_OUT_BIT]  = left_clk_div;
		stat_word[ECD_RIGHT_BASE + ECD_RUN_BIT] = right_run;
		stat_word[ECD_RIGHT_BASE + ECD_OUT_BIT] = right_clk_div;
	end

	// Bus sequencing. One wait state is inserted on every access so that
	// read data and the error flag come from flip-flops; the write lands
	// on the edge where the master samples pready high.
	always_comb begin
		next_st = st;
		next_st.pready  = 1'b0;
		next_st.pslverr = 1'b0;
		next_st.prdata  = 32'h0000_0000;
		if (access && !st.pready) begin
			// First access cycle: prepare the answer.
			next_st.pready = 1'b1;
			if (hit_ctrl) begin
				next_st.prdata = pwrite ? 32'h0000_0000 : st.ctrl;
			end else if (hit_stat) begin
				next_st.prdata = pwrite ? 32'h0000_0000 : stat_word;
			end else begin
				// Unmapped address answers with an error and zero data.
				next_st.pslverr = 1'b1;
			end
		end else if (access && st.pready) begin
			// Completing edge: only now does a write take effect.
			if (pwrite && hit_ctrl) begin
				next_st.ctrl = merge(st.ctrl, pwdata, pstrb);
			end
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st.ctrl    <= ECD_CTRL_RST;
			st.pready  <= 1'b0;
			st.prdata  <= 32'h0000_0000;
			st.pslverr <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign pready  = st.pready;
	assign prdata  = st.prdata;
	assign pslverr = st.pslverr;

	// Left side divider, fully independent of the right one.
	ecd_divider u_left (
		.clk             (clk),
		.rst_n           (rst_n),
		.div_rst         (st.ctrl[ECD_LEFT_BASE + ECD_RST_BIT]),
		.release_req     (st.ctrl[ECD_LEFT_BASE + ECD_REL_BIT]),
		.ratio           (st.ctrl[ECD_LEFT_BASE + ECD_RATIO_LSB +: 2]),
		.src_sel         (st.ctrl[ECD_LEFT_BASE + ECD_SRC_BIT]),
		.pll_primary_out (left_pll_primary_out),
		.edge_clock_in   (left_edge_clock_in),
		.running         (left_run),
		.clk_div         (left_clk_div)
	);

	// Right side divider with its own controls, inputs and output.
	ecd_divider u_right (
		.clk             (clk),
		.rst_n           (rst_n),
		.div_rst         (st.ctrl[ECD_RIGHT_BASE + ECD_RST_BIT]),
		.release_req     (st.ctrl[ECD_RIGHT_BASE + ECD_REL_BIT]),
		.ratio           (st.ctrl[ECD_RIGHT_BASE + ECD_RATIO_LSB +: 2]),
		.src_sel         (st.ctrl[ECD_RIGHT_BASE + ECD_SRC_BIT]),
		.pll_primary_out (right_pll_primary_out),
		.edge_clock_in   (right_edge_clock_in),
		.running         (right_run),
		.clk_div         (right_clk_div)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_sides_split: assert property (
		st.ctrl[ECD_LEFT_BASE + ECD_RST_BIT] && !right_run
		&& st.ctrl[ECD_RIGHT_BASE + ECD_REL_BIT]
		&& !st.ctrl[ECD_RIGHT_BASE + ECD_RST_BIT] |=> !left_clk_div
		&& right_run)
		else $error("one side's reset disturbed the other side");

	a_net_drive: assert property (
		$rose(left_clk_div) |-> left_run && $past(left_run))
		else $error("left clock net driven while divider idle");

	a_ctrl_reset: assert property (
		$rose(rst_n) |-> !left_clk_div && !right_clk_div
		&& st.ctrl == ECD_CTRL_RST)
		else $error("divided outputs not low after reset");

	a_apb_wait: assert property (
		access && !pready |=> pready ##1 !pready)
		else $error("APB answer not given after one wait state");

	c_apb_write: cover property (access && pready && pwrite && hit_ctrl);
	c_both_run: cover property (left_run && right_run);

endmodule // ecd_top

// [sim/ecd_src.sv]
// Behavioural clock sources feeding one divider side.
`timescale 1ns/1ps
module ecd_src #(
	parameter int PLL_HALF  = 16,
	parameter int EDGE_HALF = 24
) (
	output logic pll_primary_out,
	output logic edge_clock_in
);
	// Both sources start low and run free, as a locked PLL would.
	initial begin
		pll_primary_out = 1'h0;
		edge_clock_in   = 1'h0;
	end

	// The two periods differ so that a wrong source pick shows up.
	always #(PLL_HALF) pll_primary_out = ~pll_primary_out;
	always #(EDGE_HALF) edge_clock_in = ~edge_clock_in;
endmodule // ecd_src

// [sim/ecd_top_test.sv]
// Self-checking bench for the edge clock divider pair.
`timescale 1ns/1ps
module ecd_top_test
	import ecd_pkg::*;
;
	logic                  clk     = 1'h0;
	logic                  rst_n   = 1'h0;
	logic [ECD_ADDR_W-1:0] paddr   = '0;
	logic                  psel    = 1'h0;
	logic                  penable = 1'h0;
	logic                  pwrite  = 1'h0;
	logic [31:0]           pwdata  = 32'h0;
	logic [3:0]            pstrb   = 4'h0;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  l_pll, l_edge, r_pll, r_edge, l_div, r_div;
	logic [31:0]           d;
	logic                  e;
	logic [3:0]            strb = 4'hF; // Byte strobes for the next write.
	int                    miscompares = 0;
	int                    cmp_count   = 0;
	int                    cycles      = 0;
	// Ratio codes and the divide factor each one must give.
	logic [1:0] code [4] = '{ECD_DIV2, ECD_DIV4, ECD_DIV8, 2'h3};
	int         nval [4] = '{2, 4, 8, 8};

	// A 4 ns system clock.
	always #2 clk = ~clk;

	ecd_top i_dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .left_pll_primary_out(l_pll),
		.left_edge_clock_in(l_edge), .right_pll_primary_out(r_pll),
		.right_edge_clock_in(r_edge), .left_clk_div(l_div),
		.right_clk_div(r_div));
	ecd_src i_lsrc (.pll_primary_out(l_pll), .edge_clock_in(l_edge));
	ecd_src i_rsrc (.pll_primary_out(r_pll), .edge_clock_in(r_edge));

	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Cuts a hang short; the full run needs well under two thousand cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic cmp(input string what, input logic [31:0] ex, got);
		cmp_count++;
		if (got !== ex) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, ex, got);
		end
	endtask

	// One APB transfer; it opens at a fresh edge, so no signal is set twice.
	task automatic apb(input logic wr, input logic [ECD_ADDR_W-1:0] a,
		input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= strb;
		@(posedge clk);
		penable <= 1'h1;
		// Only the bench timeout ends this wait.
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		d = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Control word, same settings on both sides; right uses the edge clock.
	function automatic logic [31:0] both(logic r, logic l, logic [1:0] q);
		return {19'h0, ECD_SRC_EDGE, q, l, r, 3'h0, ECD_SRC_PLL, q, l, r};
	endfunction

	// Counts cycles until the chosen output next rises, sampled mid-cycle.
	task automatic rises(input logic right, output int gap);
		logic prev, cur, hit;
		prev = right ? r_div : l_div;
		gap = 0;
		do begin
			@(negedge clk);
			gap++;
			cur = right ? r_div : l_div;
			hit = (cur === 1'h1) && (prev === 1'h0);
			prev = cur;
		end while (!hit && gap < 400);
	endtask

	// Counts the cycles in which each output is not low.
	task automatic quiet(input int n, output int hl, output int hr);
		hl = 0;
		hr = 0;
		repeat (n) begin
			@(negedge clk);
			hl += int'(l_div !== 1'h0);
			hr += int'(r_div !== 1'h0);
		end
	endtask

	// Reset values, an unmapped address and an ignored status write.
	task automatic t_regs();
		int hl, hr;
		apb(1'h0, ECD_CTRL_OFS, 32'h0);
		cmp("ctrl reset", ECD_CTRL_RST, d);
		apb(1'h0, 12'h008, 32'h0);
		cmp("unmapped err", 32'h1, 32'(e));
		apb(1'h1, ECD_STAT_OFS, 32'hFFFF_FFFF);
		apb(1'h0, ECD_STAT_OFS, 32'h0);
		cmp("status idle", 32'h0, d);
		// Only byte 1 is strobed: right side stays held in reset.
		strb = 4'h2;
		apb(1'h1, ECD_CTRL_OFS, 32'hFFFF_FFFF);
		strb = 4'hF;
		apb(1'h0, ECD_CTRL_OFS, 32'h0);
		cmp("ctrl byte write", 32'h0000_FF01, d);
		quiet(60, hl, hr);
		cmp("outputs in reset", 32'h0, 32'(hl + hr));
	endtask

	// Out of reset but not released: outputs must stay low.
	task automatic t_hold();
		int hl, hr;
		apb(1'h1, ECD_CTRL_OFS, both(1'h0, 1'h0, ECD_DIV2));
		quiet(100, hl, hr);
		cmp("outputs unreleased", 32'h0, 32'(hl + hr));
	endtask

	// Every ratio code on both sides; left first edge, both periods and status.
	task automatic t_ratio();
		int g;
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, ECD_CTRL_OFS, both(1'h1, 1'h0, code[i]));
			apb(1'h1, ECD_CTRL_OFS, both(1'h0, 1'h1, code[i]));
			rises(1'h0, g);
			cmp("left first rise", 32'h1, 32'(g <= 14));
			rises(1'h0, g);
			cmp("left period", 32'(nval[i] * 8), 32'(g));
			rises(1'h1, g);
			rises(1'h1, g);
			cmp("right period", 32'(nval[i] * 12), 32'(g));
			apb(1'h0, ECD_STAT_OFS, 32'h0);
			cmp("running", 32'h101, d & 32'h101);
		end
	endtask

	// Left reset in mid-run, with release still set; right runs on.
	task automatic t_mid();
		int hl, hr;
		apb(1'h1, ECD_CTRL_OFS, both(1'h0, 1'h1, 2'h3) | 32'h1);
		repeat (2) @(posedge clk);
		quiet(100, hl, hr);
		cmp("left held low", 32'h0, 32'(hl));
		cmp("right still runs", 32'h1, 32'(hr > 0));
		apb(1'h0, ECD_STAT_OFS, 32'h0);
		cmp("status split", 32'h100, d & 32'h101);
	endtask

	// System reset in mid-run: control word and outputs go back to reset.
	task automatic t_rst();
		int hl, hr;
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		apb(1'h0, ECD_CTRL_OFS, 32'h0);
		cmp("ctrl after reset", ECD_CTRL_RST, d);
		quiet(40, hl, hr);
		cmp("outputs after reset", 32'h0, 32'(hl + hr));
	endtask

	// Main sequence: reset for 20 cycles, then each scenario in turn.
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		t_regs();
		t_hold();
		t_ratio();
		t_mid();
		t_rst();
		final_report();
	end
endmodule // ecd_top_test
